// File: logic/hbr_defs.svh
// Constants of the heartbeat supervisor and periodic status reporter.
// Assumes a CAN controller that hands over whole frames on one clock.
// Operation
// - Heartbeat: node FEh, function 1Fh, flag 00h, one data byte 00h.
// - Heartbeat timeout is 100 ms after reset.
// - No heartbeat within the timeout puts outputs to the safe value.
// - Safe mode locks outputs and ignores changes until heartbeats return.
// - Timeout is a 32-bit millisecond count, 10 up to the maximum.
// - Millisecond values travel as four bytes, least significant first.
// - Timeout write 20h/00h is stored, applied at once, echoed with ack.
// - Remote frame 20h with length four returns the timeout with ack.
// - Status is reported unprompted once every reporting period.
// - Period flag selects report: 00h all, 01h outputs, 02h inputs.
// - Only one report type is active at any time.
// - A reporting period of zero stops automatic reports.
// - A nonzero period is a 32-bit millisecond count from 10 up.
// - Period write 21h is stored, applied at once, echoed with ack.
// - Remote frame 21h returns the current period with ack.
// - After reset combined status is reported every second.
`ifndef HBR_DEFS_SVH
`define HBR_DEFS_SVH
`define HBR_FC_HB 8'h1f
`define HBR_FC_TMO 8'h20
`define HBR_FC_PER 8'h21
`define HBR_FC_IO 8'h10
`define HBR_HB_NODE 8'hfe
`define HBR_HB_DATA 8'h00
`define HBR_ADV_ZERO 8'h00
`define HBR_ADV_MAX 8'h02
`define HBR_DLC_ONE 4'h1
`define HBR_DLC_TWO 4'h2
`define HBR_DLC_FOUR 4'h4
`define HBR_TMO_RST 32'h0000_0064
`define HBR_PER_RST 32'h0000_03e8
`define HBR_MS_MIN 32'h0000_000a
`define HBR_MS_NS 32'h000f_4240
`define HBR_CLK_NS 32'h0000_0064
`define HBR_A_OUT 8'h00
`define HBR_A_SAFE 8'h04
`define HBR_A_STAT 8'h08
`define HBR_A_TMO 8'h0c
`define HBR_A_PER 8'h10
`define HBR_NV_TMO 1'b0
`define HBR_NV_PER 1'b1
`endif

// File: logic/hbr_pkg.sv
// Types shared by the heartbeat and reporting logic.
// Assumes frames use the 29-bit extended identifier.
package hbr_pkg;
  typedef struct packed {
    logic [3:0] rsv;
    logic ack;
    logic [7:0] fc;
    logic [7:0] node;
    logic [7:0] adv;
  } hbr_id_t;
  typedef struct packed {
    hbr_id_t id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } hbr_frame_t;
  typedef enum logic [1:0] {
    HBR_RPT_ALL = 2'h0,
    HBR_RPT_OUT = 2'h1,
    HBR_RPT_IN = 2'h2
  } hbr_rtype_t;
endpackage

// File: logic/hbr_top.sv
// Heartbeat supervisor and periodic status reporter of an I/O node.
// Assumes rx and tx frames come from a CAN controller on mclk_i and
// that node_id_i and din_i are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "hbr_defs.svh"
module hbr_top
  import hbr_pkg::*;
#(
  parameter int unsigned MS_CYC = `HBR_MS_NS / `HBR_CLK_NS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_valid_i,
  input wire hbr_frame_t rx_frame_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output hbr_frame_t tx_frame_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] node_id_i,
  input wire logic [7:0] din_i,
  output logic [7:0] dout_o,
  output logic safe_o,
  output logic nv_wr_o,
  output logic nv_sel_o,
  output logic [31:0] nv_data_o
);
  localparam logic [15:0] MS_TOP = 16'(MS_CYC - 1);

  function automatic logic known(input logic [7:0] a);
    known = (a == `HBR_A_OUT) || (a == `HBR_A_SAFE) ||
            (a == `HBR_A_STAT) || (a == `HBR_A_TMO) || (a == `HBR_A_PER);
  endfunction

  logic [7:0] node_s1_q, node_q, din_s1_q, input_byte_q;
  logic [7:0] node_s1_d, node_d, din_s1_d, input_byte_d;
  logic [15:0] div_q, div_d;
  logic tick_q, tick_d;
  logic [31:0] hb_cnt_q, hb_cnt_d, rp_cnt_q, rp_cnt_d;
  logic [31:0] tmo_q, tmo_d, per_q, per_d;
  hbr_rtype_t rtype_q, rtype_d;
  logic safe_q, safe_d, pend_q, pend_d;
  logic [7:0] out_req_q, out_req_d, safe_val_q, safe_val_d;
  logic [7:0] dout_q, dout_d;
  logic rep_free_q, rep_free_d;
  hbr_frame_t rep_q, rep_d, tx_q, tx_d;
  logic tx_v_q, tx_v_d;
  logic nv_wr_q, nv_wr_d, nv_sel_q, nv_sel_d;
  logic [31:0] nv_data_q, nv_data_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic take, hb, mine, tmo_wr, tmo_rd, per_wr, per_rd, apb_wr;
  logic [31:0] val;
  hbr_id_t rid;

  always_comb begin
    rid = rx_frame_i.id;
    val = rx_frame_i.data[31:0];
    take = rx_valid_i && rep_free_q;
    hb = take && rid.fc == `HBR_FC_HB && rid.node == `HBR_HB_NODE &&
         rid.adv == `HBR_ADV_ZERO && !rx_frame_i.rtr && !rid.ack &&
         rx_frame_i.dlc == `HBR_DLC_ONE &&
         rx_frame_i.data[7:0] == `HBR_HB_DATA;
    mine = take && rid.node == node_q && !rid.ack;
    tmo_wr = mine && rid.fc == `HBR_FC_TMO && rid.adv == `HBR_ADV_ZERO &&
             !rx_frame_i.rtr && rx_frame_i.dlc == `HBR_DLC_FOUR &&
             val >= `HBR_MS_MIN;
    tmo_rd = mine && rid.fc == `HBR_FC_TMO && rx_frame_i.rtr &&
             rx_frame_i.dlc == `HBR_DLC_FOUR;
    per_wr = mine && rid.fc == `HBR_FC_PER && rid.adv <= `HBR_ADV_MAX &&
             !rx_frame_i.rtr && rx_frame_i.dlc == `HBR_DLC_FOUR &&
             (val == 32'h0 || val >= `HBR_MS_MIN);
    per_rd = mine && rid.fc == `HBR_FC_PER && rid.adv <= `HBR_ADV_MAX &&
             rx_frame_i.rtr && rx_frame_i.dlc == `HBR_DLC_FOUR;
    apb_wr = psel_i && penable_i && pready_q && pwrite_i;

    node_s1_d = node_id_i;
    node_d = node_s1_q;
    din_s1_d = din_i;
    input_byte_d = din_s1_q;

    // The millisecond tick is a free-running divider of the system clock.
    tick_d = (div_q == MS_TOP);
    div_d = tick_d ? 16'h0 : div_q + 16'h1;

    tmo_d = tmo_q;
    per_d = per_q;
    rtype_d = rtype_q;
    if (tmo_wr) begin
      tmo_d = val;
    end
    if (per_wr) begin
      per_d = val;
      rtype_d = hbr_rtype_t'(rid.adv[1:0]);
    end

    // A heartbeat in the cycle of expiry wins, so the node stays live.
    hb_cnt_d = hb_cnt_q;
    safe_d = safe_q;
    if (hb || tmo_wr) begin
      hb_cnt_d = 32'h0;
    end else if (tick_q && !safe_q) begin
      if (hb_cnt_q >= tmo_q - 32'h1) begin
        safe_d = 1'b1;
      end else begin
        hb_cnt_d = hb_cnt_q + 32'h1;
      end
    end
    if (hb) begin
      safe_d = 1'b0;
    end

    rp_cnt_d = rp_cnt_q;
    pend_d = pend_q;
    if (per_wr) begin
      rp_cnt_d = 32'h0;
    end else if (tick_q && per_q != 32'h0) begin
      if (rp_cnt_q >= per_q - 32'h1) begin
        rp_cnt_d = 32'h0;
      end else begin
        rp_cnt_d = rp_cnt_q + 32'h1;
      end
    end

    out_req_d = out_req_q;
    safe_val_d = safe_val_q;
    if (apb_wr && paddr_i == `HBR_A_OUT && !safe_q) begin
      out_req_d = pwdata_i[7:0];
    end
    if (apb_wr && paddr_i == `HBR_A_SAFE) begin
      safe_val_d = pwdata_i[7:0];
    end
    dout_d = safe_q ? safe_val_q : out_req_q;

    rep_d = rep_q;
    rep_free_d = rep_free_q;
    if (tmo_wr || tmo_rd || per_wr || per_rd) begin
      rep_d.id = rid;
      rep_d.id.ack = 1'b1;
      rep_d.rtr = 1'b0;
      rep_d.dlc = `HBR_DLC_FOUR;
      rep_d.data = {32'h0, tmo_rd ? tmo_q : per_rd ? per_q : val};
      rep_free_d = 1'b0;
    end

    tx_d = tx_q;
    tx_v_d = tx_v_q;
    if (tx_v_q && tx_ready_i) begin
      tx_v_d = 1'b0;
    end
    // Replies go first; a report waits behind them rather than being lost.
    if (!tx_v_q || tx_ready_i) begin
      if (!rep_free_q) begin
        tx_d = rep_q;
        tx_v_d = 1'b1;
        rep_free_d = 1'b1;
      end else if (pend_q) begin
        tx_v_d = 1'b1;
        pend_d = 1'b0;
        tx_d.id = '{rsv: 4'h0, ack: 1'b1, fc: `HBR_FC_IO, node: node_q,
                    adv: {6'h0, rtype_q}};
        tx_d.rtr = 1'b0;
        tx_d.data = 64'h0;
        unique case (rtype_q)
          HBR_RPT_ALL: begin
            tx_d.dlc = `HBR_DLC_TWO;
            tx_d.data[15:0] = {input_byte_q, dout_q};
          end
          HBR_RPT_OUT: begin
            tx_d.dlc = `HBR_DLC_ONE;
            tx_d.data[7:0] = dout_q;
          end
          HBR_RPT_IN: begin
            tx_d.dlc = `HBR_DLC_ONE;
            tx_d.data[7:0] = input_byte_q;
          end
          default: begin
            tx_d.dlc = `HBR_DLC_ONE;
          end
        endcase
      end
    end
    // A report that falls due while the last one is taken is kept.
    if (!per_wr && tick_q && per_q != 32'h0 &&
        rp_cnt_q >= per_q - 32'h1) begin
      pend_d = 1'b1;
    end

    nv_wr_d = tmo_wr || per_wr;
    nv_sel_d = per_wr ? `HBR_NV_PER : `HBR_NV_TMO;
    nv_data_d = (tmo_wr || per_wr) ? val : nv_data_q;

    // One wait state keeps every bus output on a flip-flop.
    pready_d = psel_i && penable_i && !pready_q;
    pslverr_d = pready_d && !known(paddr_i);
    prdata_d = 32'h0;
    if (pready_d && !pwrite_i) begin
      unique case (paddr_i)
        `HBR_A_OUT: prdata_d = {24'h0, out_req_q};
        `HBR_A_SAFE: prdata_d = {24'h0, safe_val_q};
        `HBR_A_STAT: prdata_d = {8'h0, dout_q, input_byte_q, 5'h0,
                                 rtype_q, safe_q};
        `HBR_A_TMO: prdata_d = tmo_q;
        `HBR_A_PER: prdata_d = per_q;
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      node_s1_q <= 8'h0;
      node_q <= 8'h0;
      din_s1_q <= 8'h0;
      input_byte_q <= 8'h0;
      div_q <= 16'h0;
      tick_q <= 1'b0;
      hb_cnt_q <= 32'h0;
      rp_cnt_q <= 32'h0;
      tmo_q <= `HBR_TMO_RST;
      per_q <= `HBR_PER_RST;
      rtype_q <= HBR_RPT_ALL;
      safe_q <= 1'b0;
      pend_q <= 1'b0;
      out_req_q <= 8'h0;
      safe_val_q <= 8'h0;
      dout_q <= 8'h0;
      rep_free_q <= 1'b1;
      rep_q <= '0;
      tx_q <= '0;
      tx_v_q <= 1'b0;
      nv_wr_q <= 1'b0;
      nv_sel_q <= 1'b0;
      nv_data_q <= 32'h0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      node_s1_q <= node_s1_d;
      node_q <= node_d;
      din_s1_q <= din_s1_d;
      input_byte_q <= input_byte_d;
      div_q <= div_d;
      tick_q <= tick_d;
      hb_cnt_q <= hb_cnt_d;
      rp_cnt_q <= rp_cnt_d;
      tmo_q <= tmo_d;
      per_q <= per_d;
      rtype_q <= rtype_d;
      safe_q <= safe_d;
      pend_q <= pend_d;
      out_req_q <= out_req_d;
      safe_val_q <= safe_val_d;
      dout_q <= dout_d;
      rep_free_q <= rep_free_d;
      rep_q <= rep_d;
      tx_q <= tx_d;
      tx_v_q <= tx_v_d;
      nv_wr_q <= nv_wr_d;
      nv_sel_q <= nv_sel_d;
      nv_data_q <= nv_data_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign rx_ready_o = rep_free_q;
  assign tx_valid_o = tx_v_q;
  assign tx_frame_o = tx_q;
  assign dout_o = dout_q;
  assign safe_o = safe_q;
  assign nv_wr_o = nv_wr_q;
  assign nv_sel_o = nv_sel_q;
  assign nv_data_o = nv_data_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  safe_entry_a: assert property (
    tick_q && !safe_q && !hb && !tmo_wr && hb_cnt_q >= tmo_q - 32'h1
    |=> safe_q ##1 dout_q == safe_val_q)
    else $error("safe mode not entered on timeout");
  safe_lock_a: assert property (
    safe_q && $past(safe_q) |-> dout_q == $past(safe_val_q))
    else $error("outputs not locked to safe value");
  hb_restart_a: assert property (
    hb || tmo_wr |=> hb_cnt_q == 32'h0 &&
    safe_q == ($past(safe_q) && !$past(hb)))
    else $error("heartbeat count not restarted");
  tmo_store_a: assert property (
    tmo_wr |=> tmo_q == $past(val) && nv_wr_q && nv_data_q == tmo_q)
    else $error("timeout write not applied");
  tmo_range_a: assert property (
    mine && rid.fc == `HBR_FC_TMO && !rx_frame_i.rtr && val < `HBR_MS_MIN
    |=> $stable(tmo_q) && rep_free_q)
    else $error("short timeout accepted");
  tmo_reply_a: assert property (
    tmo_rd |=> !rep_free_q && rep_q.id.ack && rep_q.data[31:0] == tmo_q)
    else $error("timeout query reply wrong");
  per_type_a: assert property (
    per_wr |=> per_q == $past(val) && rtype_q == $past(rid.adv[1:0]))
    else $error("period write not applied");
  per_stop_a: assert property (
    per_q == 32'h0 && !pend_q |=> !pend_q)
    else $error("report pending with zero period");
  per_fire_a: assert property (
    tick_q && per_q != 32'h0 && !per_wr && rp_cnt_q >= per_q - 32'h1
    |=> pend_q || tx_v_q)
    else $error("due report not raised");
  node_filter_a: assert property (
    take && rid.node != node_q |=> $stable(tmo_q) && $stable(per_q))
    else $error("foreign frame changed settings");
  tx_hold_a: assert property (
    tx_v_q && !tx_ready_i |=> tx_v_q && $stable(tx_q))
    else $error("tx frame dropped under stall");
  rst_dflt_a: assert property (@(posedge mclk_i) disable iff (1'b0)
    !rst_n_i |=> tmo_q == `HBR_TMO_RST && per_q == `HBR_PER_RST)
    else $error("reset defaults wrong");

  safe_seen_c: cover property (!safe_q ##1 safe_q);
  report_c: cover property (tx_v_q && tx_ready_i && tx_q.id.fc == `HBR_FC_IO);
  tmo_wr_c: cover property (tmo_wr);
  per_rd_c: cover property (per_rd);
endmodule // hbr_top
`default_nettype wire

// File: dv/hbr_master_model.sv
// Behavioural CAN master that drives and watches the block's frame ports.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module hbr_master_model
  import hbr_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  output logic rx_valid_o,
  output hbr_frame_t rx_frame_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire hbr_frame_t tx_frame_i,
  output logic tx_ready_o
);
  hbr_frame_t got_q[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
  end
  // Stalling acceptance makes a reply wait inside the block.
  assign tx_ready_o = ~stall_i;
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_frame_i);
    end
  end
  function automatic hbr_frame_t mk(input logic [7:0] fc, node, adv,
      input logic rtr, input logic [3:0] dlc, input logic [31:0] val);
    hbr_frame_t f;
    f.id = {4'h0, 1'b0, fc, node, adv};
    f.rtr = rtr;
    f.dlc = dlc;
    f.data = {32'h0000_0000, val};
    return f;
  endfunction
  task automatic send(input hbr_frame_t f);
    rx_frame_o <= f;
    rx_valid_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (rx_ready_i !== 1'b1);
    // A released frame shows the inverse, so stale data cannot match.
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~f;
    @(posedge clk_i);
  endtask
  task automatic beat();
    send(mk(8'h1f, 8'hfe, 8'h00, 1'b0, 4'h1, 32'h0000_0000));
  endtask
endmodule // hbr_master_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the heartbeat supervisor and status reporter.
// Assumes the package, the design and the master model compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hbr_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, stall, pready, pslverr;
  logic rx_valid, rx_ready, tx_valid, tx_ready, nv_wr, nv_sel, safe;
  logic [7:0] paddr, din, dout;
  logic [31:0] pwdata, prdata, nv_data, rd;
  logic er;
  hbr_frame_t rx_frame, tx_frame, f;
  int err_count = 0;
  int checks_done = 0;
  int nv_tmo = 0;
  int nv_per = 0;
  localparam logic [7:0] own_node = 8'h0a;
  hbr_top #(.MS_CYC(10)) DUT (.mclk_i(mclk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid),
    .rx_frame_i(rx_frame), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
    .tx_frame_o(tx_frame), .tx_ready_i(tx_ready), .node_id_i(own_node),
    .din_i(din), .dout_o(dout), .safe_o(safe), .nv_wr_o(nv_wr),
    .nv_sel_o(nv_sel), .nv_data_o(nv_data));
  hbr_master_model mst (.clk_i(mclk), .stall_i(stall),
    .rx_valid_o(rx_valid), .rx_frame_o(rx_frame), .rx_ready_i(rx_ready),
    .tx_valid_i(tx_valid), .tx_frame_i(tx_frame), .tx_ready_o(tx_ready));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Store pulses are counted per target so that each one can be judged.
  always @(posedge mclk) begin
    if (nv_wr === 1'b1) begin
      if (nv_sel === 1'b1) begin
        nv_per++;
      end else begin
        nv_tmo++;
      end
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic get(input logic [7:0] fc);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 12000 && !hit; n++) begin
      @(posedge mclk);
      while (!hit && mst.got_q.size() > 0) begin
        f = mst.got_q.pop_front();
        hit = (f.id.fc === fc);
      end
    end
    chk(32'(hit), 32'h1, "frame arrives");
  endtask
  task automatic frm(input logic [7:0] fc, adv, input logic [3:0] dlc,
      input logic [31:0] mask, val);
    chk({3'h0, f.id}, {8'h01, fc, own_node, adv}, "identifier");
    chk({27'h0, f.rtr, f.dlc}, {28'h0, dlc}, "length");
    chk(f.data[31:0] & mask, val, "data");
  endtask
  task automatic cmd(input logic [7:0] fc, adv, input logic rtr,
      input logic [31:0] v, exp);
    mst.send(mst.mk(fc, own_node, adv, rtr, 4'h4, v));
    get(fc);
    frm(fc, adv, 4'h4, 32'hffff_ffff, exp);
  endtask
  task automatic dropped(input logic [7:0] fc, node,
      input logic [31:0] v);
    int hits;
    hits = 0;
    mst.send(mst.mk(fc, node, 8'h00, 1'b0, 4'h4, v));
    repeat (30) @(posedge mclk);
    for (int i = 0; i < mst.got_q.size(); i++) begin
      if (mst.got_q[i].id.fc === fc) hits++;
    end
    mst.got_q.delete();
    chk(32'(hits), 32'h0, "no echo");
  endtask
  task automatic t_timeout();
    cmd(8'h20, 8'h00, 1'b1, 32'h0, 32'h0000_0064);
    cmd(8'h21, 8'h00, 1'b1, 32'h0, 32'h0000_03e8);
    dropped(8'h20, own_node, 32'h0000_0009);
    stall <= 1'b1;
    mst.send(mst.mk(8'h20, own_node, 8'h00, 1'b0, 4'h4, 32'h14));
    repeat (6) @(posedge mclk);
    chk(32'(tx_valid), 32'h1, "reply held");
    stall <= 1'b0;
    get(8'h20);
    frm(8'h20, 8'h00, 4'h4, 32'hffff_ffff, 32'h0000_0014);
    chk({nv_sel, nv_data[30:0]}, 32'h0000_0014, "stored value");
    chk(32'(nv_tmo), 32'h1, "timeout stores");
    dropped(8'h20, 8'h0b, 32'h0000_0030);
    cmd(8'h20, 8'h00, 1'b1, 32'h0, 32'h0000_0014);
  endtask
  task automatic t_safe();
    apb(1'b1, 8'h00, 32'h5a);
    apb(1'b1, 8'h04, 32'ha5);
    mst.beat();
    repeat (4) @(posedge mclk);
    chk({safe, dout}, 32'h05a, "live outputs");
    repeat (260) @(posedge mclk);
    chk({safe, dout}, 32'h1a5, "safe outputs");
    apb(1'b1, 8'h00, 32'h3c);
    repeat (3) @(posedge mclk);
    chk(32'(dout), 32'ha5, "locked outputs");
    mst.beat();
    repeat (4) @(posedge mclk);
    chk({safe, dout}, 32'h05a, "outputs back");
    repeat (4) begin
      repeat (150) @(posedge mclk);
      chk(32'(safe), 32'h0, "count restarted");
      mst.beat();
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
  endtask
  task automatic t_report();
    get(8'h10);
    frm(8'h10, 8'h00, 4'h2, 32'hffff, 32'h3ca5);
    dropped(8'h21, own_node, 32'h0000_0005);
    cmd(8'h21, 8'h01, 1'b0, 32'h0f, 32'h0f);
    get(8'h10);
    frm(8'h10, 8'h01, 4'h1, 32'hff, 32'ha5);
    cmd(8'h21, 8'h02, 1'b0, 32'h0f, 32'h0f);
    repeat (2) begin
      get(8'h10);
      frm(8'h10, 8'h02, 4'h1, 32'hff, 32'h3c);
    end
    cmd(8'h21, 8'h02, 1'b1, 32'h0, 32'h0f);
    cmd(8'h21, 8'h00, 1'b0, 32'h0, 32'h0);
    repeat (200) @(posedge mclk);
    mst.got_q.delete();
    repeat (400) @(posedge mclk);
    chk(32'(mst.got_q.size()), 32'h0, "reports stopped");
    chk(32'(nv_per), 32'h3, "period stores");
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    din = 8'h3c;
    stall = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_timeout();
    t_safe();
    t_report();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
